/* File: include/weight_field_pkg.sv */
// constants, register offsets and types for the weight field and error reporter
// assumes a 25 MHz system clock and an AHB-Lite register bus with 32-bit data
package weight_field_pkg;
  // timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int HOLD_TIME_MS = 2000;
  localparam int HOLD_CYCLES  = CLK_HZ / 1000 * HOLD_TIME_MS;

  // sizes
  localparam int MEM_WORDS = 4;
  localparam int NFLT      = 7;
  localparam int NKEY      = 4;
  localparam int AOUT_W    = 16;

  // register byte offsets
  localparam logic [7:0] OFS_FMT   = 8'h00;
  localparam logic [7:0] OFS_WINT  = 8'h04;
  localparam logic [7:0] OFS_WFLT  = 8'h08;
  localparam logic [7:0] OFS_DEC   = 8'h0C;
  localparam logic [7:0] OFS_MODE  = 8'h10;
  localparam logic [7:0] OFS_ACK   = 8'h14;
  localparam logic [7:0] OFS_STATW = 8'h18;
  localparam logic [7:0] OFS_RELAY = 8'h1C;
  localparam logic [7:0] OFS_AOUT  = 8'h20;
  localparam logic [7:0] OFS_ERR   = 8'h24;
  localparam logic [7:0] OFS_HOLD  = 8'h28;
  localparam logic [7:0] OFS_VIEW  = 8'h2C;
  localparam logic [7:0] OFS_IN0   = 8'h30;
  localparam logic [7:0] OFS_OUT0  = 8'h40;

  // field positions
  localparam int FMT_FLOAT_BIT = 0;
  localparam int MODE_VIEW_BIT = 2;
  localparam int KEY_DIAG      = 0;
  localparam int KEY_PLUS      = 1;
  localparam int KEY_MINUS     = 2;
  localparam int KEY_UP        = 3;
  localparam int FLT_OVER      = 0;
  localparam int FLT_UNDER     = 1;
  localparam int FLT_EXC       = 2;
  localparam int FLT_SENSE     = 3;
  localparam int FLT_SIGHI     = 4;
  localparam int FLT_OORHI     = 5;
  localparam int FLT_OORLO     = 6;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [6:0]  RST_HOLD = 7'h00;
  localparam logic [2:0]  RST_MODE = 3'h0;

  // device states
  localparam logic [1:0] MODE_OPER   = 2'h0;
  localparam logic [1:0] MODE_REMOTE = 2'h1;

  // error codes
  localparam logic [7:0] ERR_NONE    = 8'h00;
  localparam logic [7:0] ERR_REMOTE  = 8'h01;
  localparam logic [7:0] ERR_NOTNORM = 8'h03;
  localparam logic [7:0] ERR_OVER    = 8'h05;
  localparam logic [7:0] ERR_UNDER   = 8'h07;
  localparam logic [7:0] ERR_EXC     = 8'h0A;
  localparam logic [7:0] ERR_SENSE   = 8'h0B;
  localparam logic [7:0] ERR_SIGHI   = 8'h0C;
  localparam logic [7:0] ERR_OORHI   = 8'h0D;
  localparam logic [7:0] ERR_OORLO   = 8'h0F;

  // viewer characters
  localparam logic [7:0] CHAR_OUT = 8'h6F;
  localparam logic [7:0] CHAR_IN  = 8'h69;
  localparam logic [1:0] LINE_MAX = 2'h2;

  typedef enum logic [1:0] {
    VIEW_OFF = 2'b00,
    VIEW_OUT = 2'b01,
    VIEW_IN  = 2'b11
  } view_e;
endpackage

/* File: rtl/key_hold_timer.sv */
// key hold timer: one pulse once a key has been held for a whole hold time
// assumes keyHeld is already synchronised to clk
`timescale 1ns/100ps
`default_nettype none
module key_hold_timer #(
  parameter int HOLD_CYCLES = weight_field_pkg::HOLD_CYCLES
) (
  input  wire logic clk,       // system clock
  input  wire logic rst_n,     // async reset
  input  wire logic keyHeld,   // key down and hold allowed
  output logic      heldPulse  // one cycle when hold time reached
);
  import weight_field_pkg::*;
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] CNT_END = CW'(HOLD_CYCLES);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          pulse_nxt;

  // counter saturates so the pulse fires once per press
  always_comb begin
    cnt_nxt   = cnt_r;
    pulse_nxt = 1'b0;
    if (!keyHeld) begin
      cnt_nxt = '0;
    end else if (cnt_r != CNT_END) begin
      cnt_nxt   = cnt_r + 1'b1;
      pulse_nxt = (cnt_r == CNT_END - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= '0;
      heldPulse <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      heldPulse <= pulse_nxt;
    end
  end

  a_hold_full: assert property (@(posedge clk) disable iff (!rst_n)
    heldPulse |-> $past(keyHeld) && cnt_r == CNT_END)
    else $error("hold pulse without a full hold");
endmodule
`default_nettype wire

/* File: rtl/weight_field_reporter.sv */
// weight field framer, error reporter and message memory viewer
// assumes AHB-Lite master on clk; key and fault pins are asynchronous
// Operation
// - weight format parameter byte selects integer or float weight field
// - integer mode: signed 32-bit weight in bytes 02-05, decimals in 06-07
// - float mode: IEEE single weight in bytes 02-05, significant decimals 06-07
// - multi-byte values go most significant byte at lowest address
// - viewer opens only in status view after key held two seconds
// - outgoing memory shown as hex, four bytes a line, prefix o and address
// - incoming memory shown likewise, prefix i and address
// - plus key steps window forward, minus key steps it back
// - up key leaves viewer back to status menu
// - any error drops ok, clears relays, zeroes analogue output, shows code
// - current error code readable by the control unit over the bus
// - code 000 only when operating and no error present
// - code 001 in remote set-up, 003 otherwise abnormal; weight invalid
// - code 005 over range, 007 under range
// - code 010 excitation, 011 sense voltage, 012 transducer signal too high
// - code 013 signal out of range high, 015 out of range low
// - weight errors temporary or held until cleared and cause gone; text scrolls for codes 010-012
// - outgoing byte 01 carries error code beside weight bytes 02-07
`timescale 1ns/100ps
`default_nettype none
module weight_field_reporter
  import weight_field_pkg::*;
#(
  parameter int HOLD_CYCLES = weight_field_pkg::HOLD_CYCLES,
  parameter int NRELAY      = 2
) (
  input  wire logic                 clk,        // system clock
  input  wire logic                 rst_n,      // async reset
  input  wire logic                 hsel,       // slave select
  input  wire logic [31:0]          haddr,      // byte address
  input  wire logic [1:0]           htrans,     // transfer type
  input  wire logic                 hwrite,     // write strobe
  input  wire logic [2:0]           hsize,      // word only
  input  wire logic [31:0]          hwdata,     // write data
  input  wire logic                 hready,     // bus ready
  output logic [31:0]               hrdata,     // read data
  output logic                      hreadyout,  // slave ready
  output logic                      hresp,      // always okay
  input  wire logic [weight_field_pkg::NKEY-1:0] keyPin,   // front keys
  input  wire logic [weight_field_pkg::NFLT-1:0] faultPin, // transducer faults
  output logic                      okOut,      // operating ok
  output logic [NRELAY-1:0]         relayOut,   // relay drives
  output logic [weight_field_pkg::AOUT_W-1:0] aout, // analogue level
  output logic [7:0]                errCode,    // displayed code
  output logic                      weightValid,// weight usable
  output logic                      textScroll, // scroll error text
  output logic                      viewOn,     // viewer active
  output logic [7:0]                dispPrefix, // o or i
  output logic [7:0]                dispAddr0,  // line 0 address
  output logic [31:0]               dispData0,  // line 0 bytes
  output logic [7:0]                dispAddr1,  // line 1 address
  output logic [31:0]               dispData1   // line 1 bytes
);
  import weight_field_pkg::*;
  localparam int NPIN = NKEY + NFLT;

  // pin synchronisers
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinMeta_r;
  logic [NPIN-1:0] pinSync_r;
  assign pinRaw = {faultPin, keyPin};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pinMeta_r[gi] <= 1'b0;
          pinSync_r[gi] <= 1'b0;
        end else begin
          pinMeta_r[gi] <= pinRaw[gi];
          pinSync_r[gi] <= pinMeta_r[gi];
        end
      end
    end
  endgenerate

  logic [NKEY-1:0] keyNow;
  logic [NFLT-1:0] fltNow;
  logic [NKEY-1:0] keyPrev_r;
  logic [NKEY-1:0] keyEdge;
  assign keyNow  = pinSync_r[NKEY-1:0];
  assign fltNow  = pinSync_r[NPIN-1:NKEY];
  assign keyEdge = keyNow & ~keyPrev_r;

  // priority: state first, then wiring faults, then range faults
  function automatic logic [7:0] codeOf(input logic [1:0] mode, input logic [NFLT-1:0] f);
    logic [7:0] c;
    c = ERR_NONE;
    if (mode == MODE_REMOTE)  c = ERR_REMOTE;
    else if (mode != MODE_OPER) c = ERR_NOTNORM;
    else if (f[FLT_EXC])   c = ERR_EXC;
    else if (f[FLT_SENSE]) c = ERR_SENSE;
    else if (f[FLT_SIGHI]) c = ERR_SIGHI;
    else if (f[FLT_OORHI]) c = ERR_OORHI;
    else if (f[FLT_OORLO]) c = ERR_OORLO;
    else if (f[FLT_OVER])  c = ERR_OVER;
    else if (f[FLT_UNDER]) c = ERR_UNDER;
    return c;
  endfunction

  // register file
  logic [7:0]        fmt_r, fmt_nxt;
  logic [31:0]       wInt_r, wInt_nxt, wFlt_r, wFlt_nxt, dec_r, dec_nxt;
  logic [2:0]        mode_r, mode_nxt;
  logic [7:0]        ack_r, ack_nxt;
  logic [31:0]       statW_r, statW_nxt;
  logic [NRELAY-1:0] relayReq_r, relayReq_nxt;
  logic [AOUT_W-1:0] aoutReq_r, aoutReq_nxt;
  logic [NFLT-1:0]   hold_r, hold_nxt, fltClr;
  logic [31:0]       inMem_r [MEM_WORDS];
  logic [31:0]       inMem_nxt [MEM_WORDS];
  logic              wrPend_r, wrPend_nxt;
  logic [5:0]        wrIdx_r, wrIdx_nxt;
  logic [31:0]       hrdata_nxt, rdMux;
  logic [31:0]       outMem [MEM_WORDS];
  logic [31:0]       wSel;
  logic [15:0]       decSel;
  logic [NFLT-1:0]   latch_r, latch_nxt;
  view_e             view_r;
  logic [1:0]        line_r;
  logic              accept;

  assign wSel   = fmt_r[FMT_FLOAT_BIT] ? wFlt_r : wInt_r;
  assign decSel = fmt_r[FMT_FLOAT_BIT] ? dec_r[31:16] : dec_r[15:0];
  // most significant byte first; no reordering anywhere
  assign outMem[0] = {ack_r, errCode, wSel[31:16]};
  assign outMem[1] = {wSel[15:0], decSel};
  assign outMem[2] = statW_r;
  assign outMem[3] = RST_WORD;
  assign accept    = hsel && htrans[1] && hready;

  always_comb begin
    rdMux = RST_WORD;
    case (haddr[7:2])
      OFS_FMT[7:2]:   rdMux = {24'h00_0000, fmt_r};
      OFS_WINT[7:2]:  rdMux = wInt_r;
      OFS_WFLT[7:2]:  rdMux = wFlt_r;
      OFS_DEC[7:2]:   rdMux = dec_r;
      OFS_MODE[7:2]:  rdMux = {29'h0000_0000, mode_r};
      OFS_ACK[7:2]:   rdMux = {24'h00_0000, ack_r};
      OFS_STATW[7:2]: rdMux = statW_r;
      OFS_RELAY[7:2]: rdMux = 32'(relayReq_r);
      OFS_AOUT[7:2]:  rdMux = {16'h0000, aoutReq_r};
      OFS_ERR[7:2]:   rdMux = {8'h00, fltNow, latch_r, 1'b0, okOut, errCode};
      OFS_HOLD[7:2]:  rdMux = {25'h000_0000, hold_r};
      OFS_VIEW[7:2]:  rdMux = {28'h000_0000, line_r, view_r};
      default: begin
        if (haddr[7:4] == OFS_IN0[7:4]) rdMux = inMem_r[haddr[3:2]];
        else if (haddr[7:4] == OFS_OUT0[7:4]) rdMux = outMem[haddr[3:2]];
      end
    endcase
  end

  always_comb begin
    fmt_nxt      = fmt_r;
    wInt_nxt     = wInt_r;
    wFlt_nxt     = wFlt_r;
    dec_nxt      = dec_r;
    mode_nxt     = mode_r;
    ack_nxt      = ack_r;
    statW_nxt    = statW_r;
    relayReq_nxt = relayReq_r;
    aoutReq_nxt  = aoutReq_r;
    hold_nxt     = hold_r;
    inMem_nxt    = inMem_r;
    fltClr       = '0;
    if (wrPend_r) begin
      case (wrIdx_r)
        OFS_FMT[7:2]:   fmt_nxt = hwdata[7:0];
        OFS_WINT[7:2]:  wInt_nxt = hwdata;
        OFS_WFLT[7:2]:  wFlt_nxt = hwdata;
        OFS_DEC[7:2]:   dec_nxt = hwdata;
        OFS_MODE[7:2]:  mode_nxt = hwdata[2:0];
        OFS_ACK[7:2]:   ack_nxt = hwdata[7:0];
        OFS_STATW[7:2]: statW_nxt = hwdata;
        OFS_RELAY[7:2]: relayReq_nxt = hwdata[NRELAY-1:0];
        OFS_AOUT[7:2]:  aoutReq_nxt = hwdata[AOUT_W-1:0];
        OFS_ERR[7:2]:   fltClr = hwdata[15:9];
        OFS_HOLD[7:2]:  hold_nxt = hwdata[NFLT-1:0];
        default: begin
          if (wrIdx_r[5:2] == OFS_IN0[7:4]) inMem_nxt[wrIdx_r[1:0]] = hwdata;
        end
      endcase
    end
    wrPend_nxt = accept && hwrite;
    wrIdx_nxt  = accept ? haddr[7:2] : wrIdx_r;
    hrdata_nxt = (accept && !hwrite) ? rdMux : hrdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_r      <= RST_WORD[7:0];
      wInt_r     <= RST_WORD;
      wFlt_r     <= RST_WORD;
      dec_r      <= RST_WORD;
      mode_r     <= RST_MODE;
      ack_r      <= RST_WORD[7:0];
      statW_r    <= RST_WORD;
      relayReq_r <= '0;
      aoutReq_r  <= '0;
      hold_r     <= RST_HOLD;
      for (int i = 0; i < MEM_WORDS; i++) inMem_r[i] <= RST_WORD;
      wrPend_r   <= 1'b0;
      wrIdx_r    <= '0;
      hrdata     <= RST_WORD;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      fmt_r      <= fmt_nxt;
      wInt_r     <= wInt_nxt;
      wFlt_r     <= wFlt_nxt;
      dec_r      <= dec_nxt;
      mode_r     <= mode_nxt;
      ack_r      <= ack_nxt;
      statW_r    <= statW_nxt;
      relayReq_r <= relayReq_nxt;
      aoutReq_r  <= aoutReq_nxt;
      hold_r     <= hold_nxt;
      inMem_r    <= inMem_nxt;
      wrPend_r   <= wrPend_nxt;
      wrIdx_r    <= wrIdx_nxt;
      hrdata     <= hrdata_nxt;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  // error handling; held faults stay until cleared and cause gone
  logic [NFLT-1:0]   fltEff;
  logic [7:0]        code_nxt;
  logic              err_nxt;
  always_comb begin
    latch_nxt = (latch_r & ~(fltClr & ~fltNow)) | (fltNow & hold_r);
    fltEff    = fltNow | latch_r;
    code_nxt  = codeOf(mode_r[1:0], fltEff);
    err_nxt   = (code_nxt != ERR_NONE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r     <= '0;
      errCode     <= ERR_NONE;
      okOut       <= 1'b0;
      relayOut    <= '0;
      aout        <= '0;
      weightValid <= 1'b0;
      textScroll  <= 1'b0;
    end else begin
      latch_r     <= latch_nxt;
      errCode     <= code_nxt;
      okOut       <= !err_nxt;
      relayOut    <= err_nxt ? '0 : relayReq_r;
      aout        <= err_nxt ? '0 : aoutReq_r;
      weightValid <= (mode_r[1:0] == MODE_OPER);
      textScroll  <= code_nxt >= ERR_EXC && code_nxt <= ERR_SIGHI;
    end
  end

  // message memory viewer
  logic  holdDone;
  view_e view_nxt;
  logic [1:0] line_nxt, line1;
  key_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold (
    .clk       (clk),
    .rst_n     (rst_n),
    .keyHeld   (keyNow[KEY_DIAG] && mode_r[MODE_VIEW_BIT] && view_r == VIEW_OFF),
    .heldPulse (holdDone)
  );

  always_comb begin
    view_nxt = view_r;
    line_nxt = line_r;
    case (view_r)
      VIEW_OFF: begin
        line_nxt = '0;
        if (holdDone) view_nxt = VIEW_OUT;
      end
      VIEW_OUT, VIEW_IN: begin
        if (keyEdge[KEY_UP]) begin
          view_nxt = VIEW_OFF;
        end else if (keyEdge[KEY_DIAG]) begin
          view_nxt = (view_r == VIEW_OUT) ? VIEW_IN : VIEW_OUT;
          line_nxt = '0;
        end else if (keyEdge[KEY_PLUS] && line_r < LINE_MAX) begin
          line_nxt = line_r + 1'b1;
        end else if (keyEdge[KEY_MINUS] && line_r != 2'h0) begin
          line_nxt = line_r - 1'b1;
        end
      end
      default: view_nxt = VIEW_OFF;
    endcase
    line1 = line_nxt + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyPrev_r  <= '0;
      view_r     <= VIEW_OFF;
      line_r     <= '0;
      viewOn     <= 1'b0;
      dispPrefix <= 8'h00;
      dispAddr0  <= 8'h00;
      dispAddr1  <= 8'h00;
      dispData0  <= RST_WORD;
      dispData1  <= RST_WORD;
    end else begin
      keyPrev_r  <= keyNow;
      view_r     <= view_nxt;
      line_r     <= line_nxt;
      viewOn     <= (view_nxt != VIEW_OFF);
      dispPrefix <= (view_nxt == VIEW_IN) ? CHAR_IN : CHAR_OUT;
      dispAddr0  <= {4'h0, line_nxt, 2'b00};
      dispAddr1  <= {4'h0, line1, 2'b00};
      dispData0  <= (view_nxt == VIEW_IN) ? inMem_r[line_nxt] : outMem[line_nxt];
      dispData1  <= (view_nxt == VIEW_IN) ? inMem_r[line1] : outMem[line1];
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sViewEntry;
    view_r == VIEW_OFF ##1 view_r == VIEW_OUT;
  endsequence

  a_int_bytes: assert property (!fmt_r[FMT_FLOAT_BIT] |-> outMem[0][15:0] == wInt_r[31:16]
    && outMem[1] == {wInt_r[15:0], dec_r[15:0]})
    else $error("integer weight field wrong");
  a_flt_bytes: assert property (fmt_r[FMT_FLOAT_BIT] |-> outMem[0][15:0] == wFlt_r[31:16]
    && outMem[1] == {wFlt_r[15:0], dec_r[31:16]})
    else $error("float weight field wrong");
  a_view_entry: assert property (sViewEntry |-> $past(mode_r[MODE_VIEW_BIT], 2)
    && $past(keyNow[KEY_DIAG], 2))
    else $error("viewer opened without held key in status view");
  a_view_plus: assert property (view_r != VIEW_OFF && keyEdge[KEY_PLUS] && !keyEdge[KEY_UP]
    && !keyEdge[KEY_DIAG] && line_r == 2'h0 |=> line_r == 2'h1 && dispAddr0 == 8'h04)
    else $error("plus key did not advance window");
  a_view_exit: assert property (view_r != VIEW_OFF && keyEdge[KEY_UP]
    |=> view_r == VIEW_OFF && !viewOn)
    else $error("up key did not leave viewer");
  a_err_actions: assert property (errCode != ERR_NONE |-> !okOut && relayOut == '0
    && aout == '0)
    else $error("error actions missing");
  a_ok_code: assert property (okOut |-> errCode == ERR_NONE && $past(mode_r[1:0]) == MODE_OPER)
    else $error("ok with nonzero code");
  a_remote_code: assert property (mode_r[1:0] == MODE_REMOTE ##1 mode_r[1:0] == MODE_REMOTE
    |-> errCode == ERR_REMOTE && !weightValid)
    else $error("remote state code wrong");
  a_byte01_code: assert property (outMem[0][23:16] == errCode)
    else $error("byte 01 does not carry the code");
  a_exc_code: assert property (mode_r[1:0] == MODE_OPER && fltNow[FLT_EXC]
    |=> errCode == ERR_EXC)
    else $error("excitation fault code wrong");
endmodule
`default_nettype wire

/* File: verif/fieldbus_master_model.sv */
// fieldbus master model: rebuilds the weight from outgoing message words
// assumes big-endian words, byte 00 in [31:24], as read from the device
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model (
  input  wire logic [31:0] word0,     // out bytes 00-03
  input  wire logic [31:0] word1,     // out bytes 04-07
  output logic      [31:0] weightInt, // rebuilt weight
  output logic      [31:0] weightLe,  // weight bytes as a little-endian store holds them
  output logic      [15:0] decimals   // decimal count
);
  always_comb begin
    weightInt = 32'(word0[15:0]) * 32'd65536 + 32'(word1[31:16]);
    weightLe  = {word1[23:16], word1[31:24], word0[7:0], word0[15:8]};
    decimals  = word1[15:0];
  end
endmodule
`default_nettype wire

/* File: verif/tb_weight_field_reporter.sv */
// testbench for the weight field reporter: bus, fault, mode and key stimulus
// assumes zero wait state slave and a shortened key hold time
`timescale 1ns/100ps
`default_nettype none
module tb_weight_field_reporter;
  import weight_field_pkg::*;
  localparam int HOLD = 8;
  localparam logic [7:0] CODES [7] = '{ERR_OVER, ERR_UNDER, ERR_EXC, ERR_SENSE,
                                       ERR_SIGHI, ERR_OORHI, ERR_OORLO};
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dispData0, dispData1;
  logic [31:0] m0 = 32'h0, m1 = 32'h0, mInt, mLe;
  logic [1:0]  htrans = 2'h0, relayOut;
  logic [3:0]  keyPin = 4'h0;
  logic [6:0]  faultPin = 7'h0;
  logic [15:0] aout, mDec;
  logic [7:0]  errCode, dispPrefix, dispAddr0, dispAddr1;
  logic        hreadyout, hresp, okOut, weightValid, textScroll, viewOn;
  int          miscompares = 0, testsRun = 0;
  assign hready = hreadyout;
  always #20 clk = ~clk;
  weight_field_reporter #(.HOLD_CYCLES(HOLD), .NRELAY(2)) u_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .keyPin(keyPin),
    .faultPin(faultPin), .okOut(okOut), .relayOut(relayOut), .aout(aout),
    .errCode(errCode), .weightValid(weightValid), .textScroll(textScroll),
    .viewOn(viewOn), .dispPrefix(dispPrefix), .dispAddr0(dispAddr0),
    .dispData0(dispData0), .dispAddr1(dispAddr1), .dispData1(dispData1));
  fieldbus_master_model u_master (.word0(m0), .word1(m1), .weightInt(mInt), .weightLe(mLe),
                                  .decimals(mDec));
  task end_sim;
    if (miscompares == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task bw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task br(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  task key(input int k, input int n);
    keyPin[k] <= 1'b1;
    cyc(n);
    keyPin[k] <= 1'b0;
    cyc(6);
  endtask
  task t_encode;
    bw(OFS_DEC, 32'h0003_0003);
    bw(OFS_FMT, 32'h0000_0000);
    bw(OFS_WINT, 32'h00BC_614E);
    cyc(1);
    br(OFS_OUT0, m0);
    br(OFS_OUT0 + 8'h04, m1);
    chk("int word0", m0, 32'h0000_00BC);
    chk("int word1", m1, 32'h614E_0003);
    cyc(1);
    chk("rebuilt", mInt, 32'h00BC_614E);
    chk("swapped", mLe, 32'h4E61_BC00);
    chk("decimals", 32'(mDec), 32'h0000_0003);
    bw(OFS_FMT, 32'h0000_0001);
    bw(OFS_WFLT, 32'h42F7_0000);
    cyc(1);
    br(OFS_OUT0, m0);
    br(OFS_OUT0 + 8'h04, m1);
    chk("flt word0", m0, 32'h0000_42F7);
    chk("flt word1", m1, 32'h0000_0003);
  endtask
  task t_errors;
    logic [31:0] r;
    bw(OFS_RELAY, 32'h0000_0003);
    bw(OFS_AOUT, 32'h0000_1234);
    cyc(2);
    chk("relay on", 32'(relayOut), 32'h0000_0003);
    chk("aout on", 32'(aout), 32'h0000_1234);
    for (int i = 0; i < 7; i++) begin
      faultPin <= 7'(1 << i);
      cyc(5);
      chk("code", 32'(errCode), 32'(CODES[i]));
      chk("ok off", 32'(okOut), 32'h0);
      chk("relay off", 32'(relayOut), 32'h0);
      chk("aout off", 32'(aout), 32'h0);
      chk("scroll", 32'(textScroll), 32'(i >= 2 && i <= 4));
      br(OFS_ERR, r);
      chk("code reg", 32'(r[7:0]), 32'(CODES[i]));
      br(OFS_OUT0, r);
      chk("byte01", 32'(r[23:16]), 32'(CODES[i]));
      faultPin <= 7'h00;
      cyc(5);
      chk("no error", 32'(errCode), 32'(ERR_NONE));
    end
  endtask
  task t_mode;
    logic [31:0] r;
    bw(OFS_MODE, 32'h0000_0001);
    cyc(2);
    chk("remote", 32'(errCode), 32'(ERR_REMOTE));
    chk("remote valid", 32'(weightValid), 32'h0);
    bw(OFS_MODE, 32'h0000_0002);
    cyc(2);
    chk("abnormal", 32'(errCode), 32'(ERR_NOTNORM));
    chk("abnormal ok", 32'(okOut), 32'h0);
    bw(OFS_MODE, 32'h0000_0000);
    cyc(2);
    chk("oper valid", 32'(weightValid), 32'h1);
    bw(8'h50, 32'hFFFF_FFFF);
    br(8'h50, r);
    chk("unmapped", r, 32'h0);
    bw(OFS_STATW, 32'h1234_5678);
    br(OFS_OUT0 + 8'h08, r);
    chk("status word", r, 32'h1234_5678);
    bw(OFS_HOLD, 32'h0000_0001);
    faultPin <= 7'h01;
    cyc(5);
    faultPin <= 7'h00;
    cyc(5);
    chk("held", 32'(errCode), 32'(ERR_OVER));
    bw(OFS_ERR, 32'h0000_0200);
    cyc(2);
    chk("held cleared", 32'(errCode), 32'(ERR_NONE));
    bw(OFS_HOLD, 32'h0000_0000);
  endtask
  task t_view;
    logic [31:0] r;
    bw(OFS_IN0, 32'hA1B2_C3D4);
    key(KEY_DIAG, HOLD + 12);
    chk("no status view", 32'(viewOn), 32'h0);
    bw(OFS_MODE, 32'h0000_0004);
    key(KEY_DIAG, HOLD - 4);
    chk("short hold", 32'(viewOn), 32'h0);
    key(KEY_DIAG, HOLD + 12);
    chk("view on", 32'(viewOn), 32'h1);
    chk("prefix o", 32'(dispPrefix), 32'(CHAR_OUT));
    chk("addr1", 32'(dispAddr1), 32'h4);
    chk("out data", dispData0, 32'h0000_42F7);
    chk("out data1", dispData1, 32'h0000_0003);
    br(OFS_VIEW, r);
    chk("view reg", r, 32'h0000_0001);
    key(KEY_PLUS, 3);
    chk("plus", 32'(dispAddr0), 32'h4);
    key(KEY_PLUS, 3);
    key(KEY_PLUS, 3);
    chk("plus stop", 32'(dispAddr0), 32'h8);
    key(KEY_MINUS, 3);
    key(KEY_MINUS, 3);
    chk("minus", 32'(dispAddr0), 32'h0);
    key(KEY_DIAG, 3);
    chk("prefix i", 32'(dispPrefix), 32'(CHAR_IN));
    chk("in data", dispData0, 32'hA1B2_C3D4);
    key(KEY_UP, 3);
    chk("view off", 32'(viewOn), 32'h0);
  endtask
  initial begin
    #400000;
    miscompares++;
    end_sim;
  end
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(3);
    chk("reset ok", 32'(okOut), 32'h1);
    chk("reset code", 32'(errCode), 32'(ERR_NONE));
    chk("reset resp", 32'(hresp), 32'h0);
    chk("reset ready", 32'(hreadyout), 32'h1);
    t_encode;
    t_errors;
    t_mode;
    t_view;
    end_sim;
  end
endmodule
`default_nettype wire
